// ### tb_top.sv
// Self-checking testbench for the extension bus address decoder
`timescale 1ns/1ps
module tb_top;
	typedef struct {
		logic [4:0]  cfg;
		logic        glob;
		logic        emu;
		logic        osc;
		logic [23:0] addr;
		logic [6:0]  exp;
	} xbd_row_t;
	// Expected select order: ext, ram1, ram2, can1, can2, clock, none
	xbd_row_t    rows [17] = '{
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00e100, 7'h20},
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00e7ff, 7'h20},
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00c000, 7'h40},
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00ef00, 7'h08},
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00ee80, 7'h01},
		'{5'h05, 1'h1, 1'h0, 1'h0, 24'h00ec10, 7'h01},
		'{5'h0c, 1'h1, 1'h0, 1'h0, 24'h00dfff, 7'h10},
		'{5'h02, 1'h1, 1'h0, 1'h0, 24'h00eeff, 7'h04},
		'{5'h02, 1'h1, 1'h0, 1'h0, 24'h00ef00, 7'h01},
		'{5'h00, 1'h1, 1'h0, 1'h0, 24'h00efff, 7'h40},
		'{5'h00, 1'h1, 1'h0, 1'h0, 24'h00ec00, 7'h40},
		'{5'h10, 1'h1, 1'h0, 1'h1, 24'h00ecff, 7'h02},
		'{5'h1f, 1'h0, 1'h0, 1'h0, 24'h00e000, 7'h40},
		'{5'h1f, 1'h0, 1'h0, 1'h0, 24'h00ee00, 7'h40},
		'{5'h00, 1'h0, 1'h1, 1'h0, 24'h00c000, 7'h10},
		'{5'h1f, 1'h1, 1'h0, 1'h0, 24'h123456, 7'h40},
		'{5'h1f, 1'h1, 1'h0, 1'h0, 24'h00e800, 7'h40}};
	logic        i_sys_clk, i_rst_n, i_reg_write, i_reg_read;
	logic [15:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
	logic        i_global_enable, i_emulation_mode, i_osc_off_bit;
	logic        i_power_down, i_acc_valid, i_acc_byte, i_acc_write;
	logic [23:0] i_acc_addr, o_addr;
	logic        o_sel_external, o_sel_first_ram, o_sel_second_ram;
	logic        o_sel_first_can, o_sel_second_can, o_sel_clock_cal;
	logic        o_sel_none, o_demux_16bit, o_byte_lane, o_write;
	logic        o_stack_allowed, o_bit_addressable, o_osc_stop_in_pd;
	logic        o_first_can_pins_gpio, o_second_can_pins_gpio;
	logic [1:0]  o_wait_states;
	logic [3:0]  o_segment_lines;
	logic [2:0]  o_ext_mbytes_limit;
	logic [4:0]  eff;
	int          checks, fail_count, cycles;
	xbd_decoder i_dut (.i_sys_clk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
		.i_reg_write, .i_reg_read, .o_reg_rdata, .i_global_enable,
		.i_emulation_mode, .i_osc_off_bit, .i_power_down, .i_acc_valid,
		.i_acc_addr, .i_acc_byte, .i_acc_write, .o_sel_external,
		.o_sel_first_ram, .o_sel_second_ram, .o_sel_first_can,
		.o_sel_second_can, .o_sel_clock_cal, .o_sel_none, .o_wait_states,
		.o_demux_16bit, .o_byte_lane, .o_write, .o_addr, .o_stack_allowed,
		.o_bit_addressable, .o_first_can_pins_gpio, .o_second_can_pins_gpio,
		.o_osc_stop_in_pd, .o_segment_lines, .o_ext_mbytes_limit);
	xbd_cpu_model i_cpu (.i_sys_clk, .o_acc_valid(i_acc_valid),
		.o_acc_addr(i_acc_addr), .o_acc_byte(i_acc_byte),
		.o_acc_write(i_acc_write));
	always #10 i_sys_clk = ~i_sys_clk;
	task results;
		$display("Comparisons %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Hang guard, far above the roughly 180 cycles the run needs
	always @(posedge i_sys_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			fail_count++;
			results();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_reg_write <= 1'h1;
		i_reg_addr <= a;
		i_reg_wdata <= d;
		@(posedge i_sys_clk);
		i_reg_write <= 1'h0;
	endtask
	// Read data stand only in the cycle after the strobe
	task rd(input logic [15:0] a, input logic [15:0] e);
		@(posedge i_sys_clk);
		i_reg_read <= 1'h1;
		i_reg_addr <= a;
		@(posedge i_sys_clk);
		i_reg_read <= 1'h0;
		#1 chk(o_reg_rdata, e);
	endtask
	initial
	begin
		{i_sys_clk, i_rst_n, i_reg_write, i_reg_read} = 4'h0;
		{i_reg_addr, i_reg_wdata} = 32'h0;
		{i_global_enable, i_emulation_mode, i_osc_off_bit} = 3'h0;
		i_power_down = 1'h1;
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'h1;
		rd(16'hf024, 16'h0005);
		foreach (rows[i])
		begin
			@(posedge i_sys_clk);
			i_global_enable <= 1'h0;
			i_emulation_mode <= 1'h0;
			wr(16'hf024, {11'h0, rows[i].cfg});
			@(posedge i_sys_clk);
			i_global_enable <= rows[i].glob;
			i_emulation_mode <= rows[i].emu;
			i_osc_off_bit <= rows[i].osc;
			eff = rows[i].emu ? 5'h1f : rows[i].cfg;
			i_cpu.issue(rows[i].addr, i[0], i[1], i % 3);
			#1 chk({o_sel_external, o_sel_first_ram, o_sel_second_ram,
				o_sel_first_can, o_sel_second_can, o_sel_clock_cal,
				o_sel_none}, rows[i].exp);
			chk(o_wait_states, (|rows[i].exp[3:2]) ? 2 : 0);
			chk(o_demux_16bit, |rows[i].exp[5:2]);
			chk({o_addr, o_byte_lane, o_write}, {rows[i].addr, i[0], i[1]});
			chk({o_bit_addressable, o_stack_allowed & |rows[i].exp[5:4]}, 0);
			if (rows[i].glob | rows[i].emu)
			begin
				chk({o_first_can_pins_gpio, o_second_can_pins_gpio},
					{~eff[0], ~eff[1]});
				chk(o_segment_lines, (|eff[1:0]) ? 4 : 8);
				if (|eff[1:0])
					chk(o_ext_mbytes_limit, 5);
				chk(o_osc_stop_in_pd, eff[4] ? rows[i].osc : 1'h1);
			end
			rd(16'hf024, {11'h0, rows[i].cfg});
		end
		@(posedge i_sys_clk);
		i_global_enable <= 1'h0;
		i_emulation_mode <= 1'h0;
		wr(16'hf024, 16'h0000);
		@(posedge i_sys_clk);
		i_global_enable <= 1'h1;
		wr(16'hf024, 16'h001f);
		rd(16'hf024, 16'h0000);
		@(posedge i_sys_clk);
		i_global_enable <= 1'h0;
		wr(16'hf024, 16'hffff);
		rd(16'hf024, 16'h001f);
		rd(16'hf026, 16'h0000);
		@(posedge i_sys_clk);
		i_power_down <= 1'h0;
		@(posedge i_sys_clk);
		#1 chk(o_osc_stop_in_pd, 1'h0);
		chk(o_sel_none, 1'h1);
		@(posedge i_sys_clk);
		i_power_down <= 1'h1;
		@(posedge i_sys_clk);
		i_rst_n <= 1'h0;
		repeat (2) @(posedge i_sys_clk);
		i_rst_n <= 1'h1;
		rd(16'hf024, 16'h0005);
		results();
	end
endmodule

// ### xbd_cpu_model.sv
// Behavioural CPU core that issues accesses into the decoder
`timescale 1ns/1ps
module xbd_cpu_model
(
	input  wire logic        i_sys_clk,
	output logic             o_acc_valid,
	output logic      [23:0] o_acc_addr,
	output logic             o_acc_byte,
	output logic             o_acc_write
);
	initial
	begin
		o_acc_valid = 1'h0;
		o_acc_addr = 24'h0;
		o_acc_byte = 1'h0;
		o_acc_write = 1'h0;
	end
	task automatic issue(input logic [23:0] addr, input logic bw,
		input logic wr, input int gap);
		repeat (gap) @(posedge i_sys_clk);
		@(posedge i_sys_clk);
		o_acc_valid <= 1'h1;
		o_acc_addr <= addr;
		o_acc_byte <= bw;
		o_acc_write <= wr;
		@(posedge i_sys_clk);
		o_acc_valid <= 1'h0;
		// Released lines never keep the old value, so stale use shows up
		o_acc_addr <= ~addr;
		o_acc_byte <= ~bw;
		o_acc_write <= ~wr;
	endtask
endmodule

// ### xbd_decoder.sv
// Extension bus peripheral address decoder with enable register
//
// Functional notes
// - Decode full 24-bit space, byte or word
// - First RAM internal when both enables set
// - First RAM range external otherwise
// - Second RAM internal when both enables set
// - Second RAM range external otherwise
// - RAM access zero wait states, 16-bit
// - RAM not stack, not bit addressable
// - First CAN range routed when enabled
// - Second CAN range routed when enabled
// - CAN accesses take two wait states
// - CAN ranges external only both disabled
// - Disabled CAN releases its port pins
// - Clock range external needs CANs off
// - Disabled RAM range goes external; disabled CAN or clock window stays claimed while a CAN is enabled
// - Enable register resets to 05h
// - Writes ignored while global enable set
// - Emulation mode forces all enables set
// - Oscillator power-down depends on clock enable
// - CAN use limits segment lines to four
`timescale 1ns/1ps
module xbd_decoder
(
	input  wire logic        i_sys_clk,
	input  wire logic        i_rst_n,
	input  wire logic [15:0] i_reg_addr,
	input  wire logic [15:0] i_reg_wdata,
	input  wire logic        i_reg_write,
	input  wire logic        i_reg_read,
	output logic      [15:0] o_reg_rdata,
	input  wire logic        i_global_enable,
	input  wire logic        i_emulation_mode,
	input  wire logic        i_osc_off_bit,
	input  wire logic        i_power_down,
	input  wire logic        i_acc_valid,
	input  wire logic [23:0] i_acc_addr,
	input  wire logic        i_acc_byte,
	input  wire logic        i_acc_write,
	output logic             o_sel_external,
	output logic             o_sel_first_ram,
	output logic             o_sel_second_ram,
	output logic             o_sel_first_can,
	output logic             o_sel_second_can,
	output logic             o_sel_clock_cal,
	output logic             o_sel_none,
	output logic      [1:0]  o_wait_states,
	output logic             o_demux_16bit,
	output logic             o_byte_lane,
	output logic             o_write,
	output logic      [23:0] o_addr,
	output logic             o_stack_allowed,
	output logic             o_bit_addressable,
	output logic             o_first_can_pins_gpio,
	output logic             o_second_can_pins_gpio,
	output logic             o_osc_stop_in_pd,
	output logic      [3:0]  o_segment_lines,
	output logic      [2:0]  o_ext_mbytes_limit
);
	typedef xbd_pkg::xbd_target_t xbd_target_t;

	typedef struct packed {
		logic [4:0]  enables;
		logic [15:0] rdata;
		xbd_target_t target;
		logic [23:0] addr;
		logic        byte_acc;
		logic        write;
	} xbd_state_t;

	xbd_state_t state;
	xbd_state_t next_state;

	logic       hit_ram1;
	logic       hit_ram2;
	logic       hit_can1;
	logic       hit_can2;
	logic       hit_clk;
	logic [4:0] eff;
	logic       glob_en;

	// Every check below runs on the system clock; all but reset_val_a rest during reset
	default clocking xbd_cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rst_n);

	// One comparator per window keeps the decode a flat priority tree
	xbd_region_match #(.LO(xbd_pkg::FIRST_RAM_LO), .HI(xbd_pkg::FIRST_RAM_HI))
		u_ram1 (.i_addr(i_acc_addr), .o_hit(hit_ram1));
	xbd_region_match #(.LO(xbd_pkg::SECOND_RAM_LO),
		.HI(xbd_pkg::SECOND_RAM_HI))
		u_ram2 (.i_addr(i_acc_addr), .o_hit(hit_ram2));
	xbd_region_match #(.LO(xbd_pkg::FIRST_CAN_LO), .HI(xbd_pkg::FIRST_CAN_HI))
		u_can1 (.i_addr(i_acc_addr), .o_hit(hit_can1));
	xbd_region_match #(.LO(xbd_pkg::SECOND_CAN_LO),
		.HI(xbd_pkg::SECOND_CAN_HI))
		u_can2 (.i_addr(i_acc_addr), .o_hit(hit_can2));
	xbd_region_match #(.LO(xbd_pkg::CLOCK_CAL_LO), .HI(xbd_pkg::CLOCK_CAL_HI))
		u_clk (.i_addr(i_acc_addr), .o_hit(hit_clk));

	function automatic logic bit_on(input logic [4:0] en, input int idx);
		bit_on = en[idx];
	endfunction

	// Emulation forces enables
	// Global enable gated here so every user sees it as a real input
	assign eff = !glob_en ? 5'h00 :
		i_emulation_mode ? xbd_pkg::ENABLE_MASK : state.enables;
	assign glob_en = i_global_enable | i_emulation_mode;

	always_comb
	begin
		next_state = state;
		next_state.rdata = 16'h0000;
		if (i_reg_write && i_reg_addr == xbd_pkg::PERIPH_ENABLE_OFFSET &&
			!i_global_enable)
		begin
			next_state.enables = i_reg_wdata[4:0];
		end
		if (i_reg_read && i_reg_addr == xbd_pkg::PERIPH_ENABLE_OFFSET)
		begin
			next_state.rdata = {11'h000, state.enables};
		end
		next_state.addr = i_acc_addr;
		next_state.byte_acc = i_acc_byte;
		next_state.write = i_acc_write;
		next_state.target = xbd_pkg::XBD_TGT_NONE;
		if (i_acc_valid)
		begin
			next_state.target = xbd_pkg::XBD_TGT_EXTERNAL;
			if (hit_ram1 && bit_on(eff, xbd_pkg::FIRST_RAM_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_FIRST_RAM;
			end
			if (hit_ram2 && bit_on(eff, xbd_pkg::SECOND_RAM_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_SECOND_RAM;
			end
			if (hit_can1 && bit_on(eff, xbd_pkg::FIRST_CAN_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_FIRST_CAN;
			end
			if (hit_can2 && bit_on(eff, xbd_pkg::SECOND_CAN_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_SECOND_CAN;
			end
			if (hit_can1 && !bit_on(eff, xbd_pkg::FIRST_CAN_BIT) &&
				bit_on(eff, xbd_pkg::SECOND_CAN_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_NONE;
			end
			if (hit_can2 && !bit_on(eff, xbd_pkg::SECOND_CAN_BIT) &&
				bit_on(eff, xbd_pkg::FIRST_CAN_BIT))
			begin
				next_state.target = xbd_pkg::XBD_TGT_NONE;
			end
			if (hit_clk)
			begin
				if (bit_on(eff, xbd_pkg::CLOCK_CAL_BIT))
				begin
					next_state.target = xbd_pkg::XBD_TGT_CLOCK_CAL;
				end
				else if (bit_on(eff, xbd_pkg::FIRST_CAN_BIT) ||
					bit_on(eff, xbd_pkg::SECOND_CAN_BIT))
				begin
					next_state.target = xbd_pkg::XBD_TGT_NONE;
				end
			end
		end
		if (!i_rst_n)
		begin
			next_state.enables = xbd_pkg::PERIPH_ENABLE_RESET[4:0];
			next_state.rdata = 16'h0000;
			next_state.target = xbd_pkg::XBD_TGT_NONE;
			next_state.addr = 24'h000000;
			next_state.byte_acc = 1'b0;
			next_state.write = 1'b0;
		end
	end

	always_ff @(posedge i_sys_clk)
	begin
		state <= next_state;
	end

	assign o_reg_rdata      = state.rdata;
	assign o_sel_external   = state.target == xbd_pkg::XBD_TGT_EXTERNAL;
	assign o_sel_first_ram  = state.target == xbd_pkg::XBD_TGT_FIRST_RAM;
	assign o_sel_second_ram = state.target == xbd_pkg::XBD_TGT_SECOND_RAM;
	assign o_sel_first_can  = state.target == xbd_pkg::XBD_TGT_FIRST_CAN;
	assign o_sel_second_can = state.target == xbd_pkg::XBD_TGT_SECOND_CAN;
	assign o_sel_clock_cal  = state.target == xbd_pkg::XBD_TGT_CLOCK_CAL;
	assign o_sel_none       = state.target == xbd_pkg::XBD_TGT_NONE;
	assign o_addr           = state.addr;
	assign o_byte_lane      = state.byte_acc;
	assign o_write          = state.write;

	assign o_wait_states = (o_sel_first_can || o_sel_second_can) ?
		xbd_pkg::CAN_WAIT_STATES : xbd_pkg::RAM_WAIT_STATES;
	assign o_demux_16bit = o_sel_first_ram || o_sel_second_ram ||
		o_sel_first_can || o_sel_second_can;

	assign o_stack_allowed   = !(o_sel_first_ram || o_sel_second_ram);
	assign o_bit_addressable = 1'b0;

	assign o_first_can_pins_gpio  = !bit_on(eff, xbd_pkg::FIRST_CAN_BIT);
	assign o_second_can_pins_gpio = !bit_on(eff, xbd_pkg::SECOND_CAN_BIT);

	assign o_osc_stop_in_pd = i_power_down &&
		(!bit_on(eff, xbd_pkg::CLOCK_CAL_BIT) || i_osc_off_bit);

	assign o_segment_lines = (bit_on(eff, xbd_pkg::FIRST_CAN_BIT) ||
		bit_on(eff, xbd_pkg::SECOND_CAN_BIT)) ?
		{1'b0, xbd_pkg::SEG_LINES_WITH_CAN} : xbd_pkg::SEG_LINES_FULL;
	assign o_ext_mbytes_limit = xbd_pkg::EXT_MBYTES_WITH_CAN;

	lock_hold_a: assert property (
		i_global_enable && !i_emulation_mode |=> $stable(state.enables))
		else $error("enable register changed while locked");
	ram1_sel_a: assert property (
		i_acc_valid && hit_ram1 && i_global_enable && state.enables[2]
		|=> o_sel_first_ram)
		else $error("first ram not selected");
	ram1_ext_a: assert property (
		i_acc_valid && hit_ram1 && !i_emulation_mode &&
		!(i_global_enable && state.enables[2]) |=> o_sel_external)
		else $error("first ram range not external");
	ram2_sel_a: assert property (
		i_acc_valid && hit_ram2 && i_global_enable && state.enables[3]
		|=> o_sel_second_ram)
		else $error("second ram not selected");
	ram2_ext_a: assert property (
		i_acc_valid && hit_ram2 && !i_emulation_mode &&
		!(i_global_enable && state.enables[3]) |=> o_sel_external)
		else $error("second ram range not external");
	can1_sel_a: assert property (
		i_acc_valid && hit_can1 && i_global_enable && state.enables[0]
		|=> o_sel_first_can)
		else $error("first can not selected");
	can2_sel_a: assert property (
		i_acc_valid && hit_can2 && i_global_enable && state.enables[1]
		|=> o_sel_second_can)
		else $error("second can not selected");
	can_wait_a: assert property (
		o_sel_first_can || o_sel_second_can |-> o_wait_states == 2'h2)
		else $error("can wait states wrong");
	ram_fast_a: assert property (
		o_sel_first_ram || o_sel_second_ram |->
		o_wait_states == 2'h0 && o_demux_16bit)
		else $error("ram access not zero wait 16-bit");
	ram_restrict_a: assert property (
		o_sel_first_ram || o_sel_second_ram |->
		!o_stack_allowed && !o_bit_addressable)
		else $error("ram offered as stack or bit space");
	upper_zero_a: assert property (
		o_reg_rdata[15:5] == 11'h000)
		else $error("upper bits not zero");
	// Reset value, checked through reset itself
	reset_val_a: assert property (disable iff (1'b0)
		!i_rst_n |=> state.enables == 5'h05)
		else $error("reset value wrong");
	can_claim_a: assert property (
		i_acc_valid && hit_can2 && i_global_enable && !i_emulation_mode &&
		state.enables[1:0] == 2'h1 |=> o_sel_none)
		else $error("can window leaked");
	can1_claim_a: assert property (
		i_acc_valid && hit_can1 && i_global_enable && !i_emulation_mode &&
		state.enables[1:0] == 2'h2 |=> o_sel_none)
		else $error("first can window leaked");
	can_ext_a: assert property (
		i_acc_valid && (hit_can1 || hit_can2) && !i_emulation_mode &&
		state.enables[1:0] == 2'h0 |=> o_sel_external)
		else $error("can window not external");
	clk_sel_a: assert property (
		i_acc_valid && hit_clk && i_global_enable && state.enables[4]
		|=> o_sel_clock_cal)
		else $error("clock window not selected");
	clk_ext_a: assert property (
		i_acc_valid && hit_clk && !i_emulation_mode &&
		state.enables[4] == 1'b0 && state.enables[1:0] == 2'h0
		|=> o_sel_external)
		else $error("clock window not external");
	emu_all_a: assert property (
		i_emulation_mode && i_acc_valid && hit_ram2 |=> o_sel_second_ram)
		else $error("emulation did not enable");
	pin_free_a: assert property (
		!i_emulation_mode && !(i_global_enable && state.enables[0]) |->
		o_first_can_pins_gpio)
		else $error("first can pins not released");
	pin_held_a: assert property (
		i_global_enable && state.enables[1] |-> !o_second_can_pins_gpio)
		else $error("second can pins released while enabled");
	osc_stop_a: assert property (
		i_power_down && !i_emulation_mode &&
		!(i_global_enable && state.enables[4]) |-> o_osc_stop_in_pd)
		else $error("oscillator kept running in power-down");
	seg_lines_a: assert property (
		i_global_enable && state.enables[1:0] != 2'h0 |->
		o_segment_lines == 4'h4)
		else $error("segment lines not limited");
	idle_none_a: assert property (
		!i_acc_valid |=> o_sel_none)
		else $error("selection without an access");
	acc_copy_a: assert property (
		i_acc_valid |=> o_addr == $past(i_acc_addr) &&
		o_byte_lane == $past(i_acc_byte) && o_write == $past(i_acc_write))
		else $error("access attributes not passed on");
	ram_cov_c: cover property (@(posedge i_sys_clk) o_sel_first_ram);
	can_cov_c: cover property (@(posedge i_sys_clk) o_sel_second_can);
	ext_cov_c: cover property (@(posedge i_sys_clk) o_sel_external);
	clk_cov_c: cover property (@(posedge i_sys_clk) o_sel_clock_cal);
	lock_cov_c: cover property (@(posedge i_sys_clk)
		i_global_enable && i_reg_write);
endmodule

// ### xbd_pkg.sv
// Package of constants and types for the extension bus address decoder
package xbd_pkg;
	localparam logic [15:0] PERIPH_ENABLE_OFFSET = 16'hf024;
	localparam logic [15:0] PERIPH_ENABLE_RESET  = 16'h0005;
	localparam int          FIRST_CAN_BIT        = 0;
	localparam int          SECOND_CAN_BIT       = 1;
	localparam int          FIRST_RAM_BIT        = 2;
	localparam int          SECOND_RAM_BIT       = 3;
	localparam int          CLOCK_CAL_BIT        = 4;
	localparam logic [4:0]  ENABLE_MASK          = 5'h1f;
	localparam logic [23:0] FIRST_RAM_LO         = 24'h00e000;
	localparam logic [23:0] FIRST_RAM_HI         = 24'h00e7ff;
	localparam logic [23:0] SECOND_RAM_LO        = 24'h00c000;
	localparam logic [23:0] SECOND_RAM_HI        = 24'h00dfff;
	localparam logic [23:0] FIRST_CAN_LO         = 24'h00ef00;
	localparam logic [23:0] FIRST_CAN_HI         = 24'h00efff;
	localparam logic [23:0] SECOND_CAN_LO        = 24'h00ee00;
	localparam logic [23:0] SECOND_CAN_HI        = 24'h00eeff;
	localparam logic [23:0] CLOCK_CAL_LO         = 24'h00ec00;
	localparam logic [23:0] CLOCK_CAL_HI         = 24'h00ecff;
	localparam logic [1:0]  CAN_WAIT_STATES      = 2'h2;
	localparam logic [1:0]  RAM_WAIT_STATES      = 2'h0;
	localparam logic [2:0]  SEG_LINES_WITH_CAN   = 3'h4;
	localparam logic [3:0]  SEG_LINES_FULL       = 4'h8;
	localparam logic [2:0]  EXT_MBYTES_WITH_CAN  = 3'h5;
	typedef enum logic [2:0] {
		XBD_TGT_NONE,
		XBD_TGT_EXTERNAL,
		XBD_TGT_FIRST_RAM,
		XBD_TGT_SECOND_RAM,
		XBD_TGT_FIRST_CAN,
		XBD_TGT_SECOND_CAN,
		XBD_TGT_CLOCK_CAL
	} xbd_target_t;
endpackage

// ### xbd_region_match.sv
// Inclusive address range compare used for each decoded window
`timescale 1ns/1ps
module xbd_region_match
#(
	parameter logic [23:0] LO = 24'h000000,
	parameter logic [23:0] HI = 24'h000000
)
(
	input  wire logic [23:0] i_addr,
	output logic             o_hit
);
	assign o_hit = (i_addr >= LO) && (i_addr <= HI);
endmodule
